// [include/rioc_pkg.sv]
package rioc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int MEAS_W  = 16;
  localparam int PICK_W  = 12;
  localparam int CMP_W   = 32;
  localparam int ADR_W   = 8;
  localparam int CNT_W   = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode
  typedef enum logic [1:0] {
    RIOC_MODE_OFF  = 2'b00,
    RIOC_MODE_PEAK = 2'b01,
    RIOC_MODE_FUND = 2'b10
  } rioc_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pickup setting, in percent of rated residual current
  localparam logic [PICK_W-1:0] PICK_MIN      = 12'h00a;
  localparam logic [PICK_W-1:0] PICK_MAX      = 12'h3e8;
  localparam logic [PICK_W-1:0] PICK_MAX_WIDE = 12'hbb8;
  localparam logic [PICK_W-1:0] PICK_RST      = 12'h0c8;
  localparam logic [6:0]        PERCENT_SCALE = 7'h64;

  // Rated residual current in measurement units
  localparam logic [MEAS_W-1:0] RATED_RST = 16'h1000;

  // Peak hold window, in samples
  localparam int                WIN_SAMPLES = 20;
  localparam logic [4:0]        WIN_LAST    = 5'h13;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [ADR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADR_W-1:0] OFS_PICKUP   = 8'h04;
  localparam logic [ADR_W-1:0] OFS_RATED    = 8'h08;
  localparam logic [ADR_W-1:0] OFS_STATUS   = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [ADR_W-1:0] OFS_MEAS     = 8'h18;
  localparam logic [ADR_W-1:0] OFS_TRIP_CNT = 8'h1c;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WIDE_BIT = 4;
  localparam int ST_INT_BIT    = 0;
  localparam int ST_GEN_BIT    = 1;
  localparam int ST_BLK_BIT    = 2;
  localparam int ST_DBL_BIT    = 3;
  localparam int IRQ_W         = 3;
  localparam int IRQ_RISE_BIT  = 0;
  localparam int IRQ_FALL_BIT  = 1;
  localparam int IRQ_BLK_BIT   = 2;

  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

endpackage : rioc_pkg

// [verilog/rioc_peak_select.sv]
`timescale 1ns/100ps
`default_nettype none

module rioc_peak_select
(
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // Sample stream
  input  wire logic                              sample_valid_i,
  input  wire logic signed [rioc_pkg::MEAS_W-1:0] sample_i,
  // Peak magnitude
  output logic        [rioc_pkg::MEAS_W-1:0]     residual_peak_o,
  output logic                                   peak_valid_o
);

  logic [rioc_pkg::MEAS_W-1:0] abs_val;
  logic [rioc_pkg::MEAS_W-1:0] cur_max;
  logic [rioc_pkg::MEAS_W-1:0] prev_max;
  logic [rioc_pkg::MEAS_W-1:0] next_cur;
  logic [rioc_pkg::MEAS_W-1:0] next_peak;
  logic [4:0]                  win_cnt;

  // Most negative code maps to its true magnitude, which still fits unsigned
  assign abs_val  = sample_i[rioc_pkg::MEAS_W-1] ? (~sample_i + 1'b1) : sample_i;
  assign next_cur = (abs_val > cur_max) ? abs_val : cur_max;
  // Peak spans the finished window plus the running one, so it never drops early
  assign next_peak = (next_cur > prev_max) ? next_cur : prev_max;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_max  <= '0;
      prev_max <= '0;
      win_cnt  <= '0;
    end
    else if (sample_valid_i)
    begin
      if (win_cnt == rioc_pkg::WIN_LAST)
      begin
        prev_max <= next_cur;
        cur_max  <= '0;
        win_cnt  <= '0;
      end
      else
      begin
        cur_max <= next_cur;
        win_cnt <= win_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      residual_peak_o <= '0;
      peak_valid_o    <= 1'b0;
    end
    else
    begin
      peak_valid_o <= sample_valid_i;
      if (sample_valid_i)
      begin
        residual_peak_o <= next_peak;
      end
    end
  end

endmodule : rioc_peak_select

`default_nettype wire

// [verilog/rioc_trip_top.sv]
// Function
// - Internal trip asserts in the same evaluation where measure exceeds threshold.
// - Trip only when measure is strictly above threshold; no added delay.
// - Mode is off, peak or fundamental; off after reset.
// - Pickup percent range 10 to 1000, step 1, default 200.
// - Upper pickup bound widens to 3000 when wide-range variant is set.
// - Setting-double input doubles the effective pickup threshold.
// - Block input forces the general trip output low.
// - Peak magnitude is derived from the sampled residual current stream.
// - Compare peak or fundamental value with threshold, chosen by mode.
// - General trip combines internal trip with the block input.
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rioc_trip_top
(
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // Wishbone slave
  input  wire logic                              wb_cyc_i,
  input  wire logic                              wb_stb_i,
  input  wire logic                              wb_we_i,
  input  wire logic [rioc_pkg::ADR_W-1:0]        wb_adr_i,
  input  wire logic [3:0]                        wb_sel_i,
  input  wire logic [31:0]                       wb_dat_i,
  output logic      [31:0]                       wb_dat_o,
  output logic                                   wb_ack_o,
  // Measurement front end
  input  wire logic                              sample_valid_i,
  input  wire logic signed [rioc_pkg::MEAS_W-1:0] sample_i,
  input  wire logic                              rms_valid_i,
  input  wire logic [rioc_pkg::MEAS_W-1:0]       fundamental_rms_i,
  // Binary inputs from user logic
  input  wire logic                              setting_double_in_i,
  input  wire logic                              function_block_in_i,
  // Trip outputs
  output logic                                   internal_trip_o,
  output logic                                   general_trip_out_o,
  // Interrupt
  output logic                                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  rioc_pkg::rioc_mode_t                mode;
  logic                                wide_range;
  logic [rioc_pkg::PICK_W-1:0]         pickup;
  logic [rioc_pkg::MEAS_W-1:0]         rated;
  logic [rioc_pkg::IRQ_W-1:0]          irq_stat;
  logic [rioc_pkg::IRQ_W-1:0]          irq_mask;
  logic [rioc_pkg::MEAS_W-1:0]         meas_q;
  logic [rioc_pkg::CNT_W-1:0]          trip_cnt;
  logic [1:0]                          dbl_sync;
  logic [1:0]                          blk_sync;
  logic                                blk_q;
  logic                                dbl_s;
  logic                                blk_s;
  logic [rioc_pkg::MEAS_W-1:0]         residual_peak;
  logic                                peak_valid;
  logic                                eval;
  logic [rioc_pkg::MEAS_W-1:0]         new_meas;
  logic [rioc_pkg::MEAS_W-1:0]         next_meas;
  logic [rioc_pkg::PICK_W-1:0]         pick_max;
  logic [rioc_pkg::PICK_W-1:0]         pick_eff;
  logic [rioc_pkg::CMP_W-1:0]          meas_scaled;
  logic [rioc_pkg::CMP_W-1:0]          thr_base;
  logic [rioc_pkg::CMP_W-1:0]          thr_eff;
  logic                                mode_on;
  logic                                next_internal;
  logic                                next_general;
  logic                                wb_req;
  logic                                wb_wr;
  logic [31:0]                         wr_word;
  logic [rioc_pkg::PICK_W-1:0]         wr_pick;
  logic                                wr_pick_ok;
  logic [1:0]                          wr_mode;
  logic [rioc_pkg::IRQ_W-1:0]          irq_set;
  logic [31:0]                         next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Binary inputs come from outside this clock domain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dbl_sync <= 2'h0;
      blk_sync <= 2'h0;
    end
    else
    begin
      dbl_sync <= {dbl_sync[0], setting_double_in_i};
      blk_sync <= {blk_sync[0], function_block_in_i};
    end
  end

  assign dbl_s = dbl_sync[1];
  assign blk_s = blk_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Peak selection
  rioc_peak_select u_peak
  (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .sample_valid_i  (sample_valid_i),
    .sample_i        (sample_i),
    .residual_peak_o (residual_peak),
    .peak_valid_o    (peak_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instantaneous decision
  assign mode_on = (mode == rioc_pkg::RIOC_MODE_PEAK) || (mode == rioc_pkg::RIOC_MODE_FUND);

  // Fundamental value is trusted as delivered by the upstream stage
  always_comb
  begin
    eval     = 1'b0;
    new_meas = meas_q;
    case (mode)
      rioc_pkg::RIOC_MODE_PEAK:
      begin
        eval     = peak_valid;
        new_meas = residual_peak;
      end
      rioc_pkg::RIOC_MODE_FUND:
      begin
        eval     = rms_valid_i;
        new_meas = fundamental_rms_i;
      end
      default:
      begin
        eval     = 1'b0;
        new_meas = '0;
      end
    endcase
  end

  assign next_meas = mode_on ? (eval ? new_meas : meas_q) : '0;

  // Stored setting may exceed the narrow bound after the wide flag is cleared
  assign pick_max = wide_range ? rioc_pkg::PICK_MAX_WIDE : rioc_pkg::PICK_MAX;
  assign pick_eff = (pickup > pick_max) ? pick_max : pickup;

  // Cross-multiplied to avoid a divider: meas*100 against pickup*rated
  assign meas_scaled = rioc_pkg::CMP_W'(next_meas) * rioc_pkg::CMP_W'(rioc_pkg::PERCENT_SCALE);
  assign thr_base    = rioc_pkg::CMP_W'(pick_eff) * rioc_pkg::CMP_W'(rated);
  assign thr_eff     = dbl_s ? (thr_base << 1) : thr_base;

  // Strict comparison, decided in the cycle the new value arrives
  assign next_internal = mode_on && (meas_scaled > thr_eff);
  assign next_general  = next_internal && !blk_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meas_q <= '0;
    end
    else
    begin
      meas_q <= next_meas;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decision logic
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      internal_trip_o    <= 1'b0;
      general_trip_out_o <= 1'b0;
      blk_q              <= 1'b0;
    end
    else
    begin
      internal_trip_o    <= next_internal;
      general_trip_out_o <= next_general;
      blk_q              <= blk_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone access
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  always_comb
  begin
    wr_word = 32'h0000_0000;
    for (int b = 0; b < 4; b++)
    begin
      wr_word[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : next_rdata[b*8 +: 8];
    end
  end

  assign wr_pick    = wr_word[rioc_pkg::PICK_W-1:0];
  assign wr_pick_ok = (wr_pick >= rioc_pkg::PICK_MIN) && (wr_pick <= pick_max);
  assign wr_mode    = wr_word[rioc_pkg::CTRL_MODE_LSB +: 2];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode       <= rioc_pkg::RIOC_MODE_OFF;
      wide_range <= 1'b0;
    end
    else if (wb_wr && (wb_adr_i == rioc_pkg::OFS_CTRL))
    begin
      // The unused code is taken as off so the function never runs undefined
      case (wr_mode)
        2'h1:    mode <= rioc_pkg::RIOC_MODE_PEAK;
        2'h2:    mode <= rioc_pkg::RIOC_MODE_FUND;
        default: mode <= rioc_pkg::RIOC_MODE_OFF;
      endcase
      wide_range <= wr_word[rioc_pkg::CTRL_WIDE_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pickup <= rioc_pkg::PICK_RST;
      rated  <= rioc_pkg::RATED_RST;
    end
    else if (wb_wr)
    begin
      if ((wb_adr_i == rioc_pkg::OFS_PICKUP) && wr_pick_ok)
      begin
        pickup <= wr_pick;
      end
      else if (wb_adr_i == rioc_pkg::OFS_RATED)
      begin
        rated <= wr_word[rioc_pkg::MEAS_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over a write-one clear in the same cycle
  assign irq_set[rioc_pkg::IRQ_RISE_BIT] = next_general && !general_trip_out_o;
  assign irq_set[rioc_pkg::IRQ_FALL_BIT] = !next_general && general_trip_out_o;
  assign irq_set[rioc_pkg::IRQ_BLK_BIT]  = blk_s != blk_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat <= '0;
    end
    else if (wb_wr && (wb_adr_i == rioc_pkg::OFS_IRQ_STAT))
    begin
      irq_stat <= (irq_stat & ~wr_word[rioc_pkg::IRQ_W-1:0]) | irq_set;
    end
    else
    begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_mask <= rioc_pkg::IRQ_MASK_RST;
    end
    else if (wb_wr && (wb_adr_i == rioc_pkg::OFS_IRQ_MASK))
    begin
      irq_mask <= wr_word[rioc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip counter: any write clears it, a rising trip in that cycle still counts
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trip_cnt <= '0;
    end
    else if (wb_wr && (wb_adr_i == rioc_pkg::OFS_TRIP_CNT))
    begin
      trip_cnt <= irq_set[rioc_pkg::IRQ_RISE_BIT] ? 16'h0001 : 16'h0000;
    end
    else if (irq_set[rioc_pkg::IRQ_RISE_BIT] && (trip_cnt != 16'hffff))
    begin
      trip_cnt <= trip_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero and are still acknowledged
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == rioc_pkg::OFS_CTRL)
    begin
      next_rdata[rioc_pkg::CTRL_MODE_LSB +: 2] = mode;
      next_rdata[rioc_pkg::CTRL_WIDE_BIT]      = wide_range;
    end
    else if (wb_adr_i == rioc_pkg::OFS_PICKUP)
    begin
      next_rdata[rioc_pkg::PICK_W-1:0] = pickup;
    end
    else if (wb_adr_i == rioc_pkg::OFS_RATED)
    begin
      next_rdata[rioc_pkg::MEAS_W-1:0] = rated;
    end
    else if (wb_adr_i == rioc_pkg::OFS_STATUS)
    begin
      next_rdata[rioc_pkg::ST_INT_BIT] = internal_trip_o;
      next_rdata[rioc_pkg::ST_GEN_BIT] = general_trip_out_o;
      next_rdata[rioc_pkg::ST_BLK_BIT] = blk_s;
      next_rdata[rioc_pkg::ST_DBL_BIT] = dbl_s;
    end
    else if (wb_adr_i == rioc_pkg::OFS_IRQ_STAT)
    begin
      next_rdata[rioc_pkg::IRQ_W-1:0] = irq_stat;
    end
    else if (wb_adr_i == rioc_pkg::OFS_IRQ_MASK)
    begin
      next_rdata[rioc_pkg::IRQ_W-1:0] = irq_mask;
    end
    else if (wb_adr_i == rioc_pkg::OFS_MEAS)
    begin
      next_rdata[rioc_pkg::MEAS_W-1:0] = meas_q;
    end
    else if (wb_adr_i == rioc_pkg::OFS_TRIP_CNT)
    begin
      next_rdata[rioc_pkg::CNT_W-1:0] = trip_cnt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule : rioc_trip_top

`default_nettype wire

// [tb/rioc_front_model.sv]
`timescale 1ns/100ps
`default_nettype none

module rioc_front_model
(
  // Clock
  input  wire logic                          clk_i,
  // Streams towards the trip block
  output logic                               sample_valid_o,
  output logic signed [rioc_pkg::MEAS_W-1:0] sample_o,
  output logic                               rms_valid_o,
  output logic        [rioc_pkg::MEAS_W-1:0] rms_o
);
  initial
  begin
    sample_valid_o = 1'b0;
    sample_o = 16'h5a5a;
    rms_valid_o = 1'b0;
    rms_o = 16'ha5a5;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Off-strobe data is inverted so stale values never look fresh
  task automatic send_samples(input logic [15:0] v, input int n);
  begin
    sample_valid_o <= 1'b1;
    sample_o <= v;
    repeat (n) @(posedge clk_i);
    sample_valid_o <= 1'b0;
    sample_o <= ~v;
  end
  endtask : send_samples

  task automatic send_rms(input logic [15:0] v);
  begin
    rms_valid_o <= 1'b1;
    rms_o <= v;
    @(posedge clk_i);
    rms_valid_o <= 1'b0;
    rms_o <= ~v;
  end
  endtask : send_rms
endmodule : rioc_front_model

`default_nettype wire

// [tb/rioc_trip_properties.sv]
`timescale 1ns/100ps
`default_nettype none

module rioc_trip_properties
(
  // Clock and reset
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  // Register bus
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [rioc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  // Trip path
  input wire logic                       function_block_in_i,
  input wire logic                       internal_trip_o,
  input wire logic                       general_trip_out_o,
  input wire logic                       irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Shadow of the mode field; code 3 behaves as off
  logic mode_off;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_off <= 1'b1;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
             && wb_adr_i == rioc_pkg::OFS_CTRL)
      mode_off <= (wb_dat_i[1:0] == 2'h0) || (wb_dat_i[1:0] == 2'h3);
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence bus_ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  reset_quiet_a:
    assert property ($past(rst_i) |-> !internal_trip_o && !general_trip_out_o && !irq_o)
    else $error("outputs active after reset");
  off_quiet_a:
    assert property (mode_off [*3] |-> !internal_trip_o && !general_trip_out_o)
    else $error("trip while mode off");
  block_gen_a:
    assert property (function_block_in_i [*4] |=> !general_trip_out_o)
    else $error("general trip while blocked");
  gen_needs_int_a:
    assert property (general_trip_out_o |-> internal_trip_o)
    else $error("general trip without internal trip");
  gen_follows_a:
    assert property ((internal_trip_o && !function_block_in_i) [*4] |-> general_trip_out_o)
    else $error("general trip missing");
  ack_answer_a:
    assert property (bus_req_s |=> bus_ack_s)
    else $error("bus ack not one cycle after request");
  ack_cause_a:
    assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i > rioc_pkg::OFS_TRIP_CNT
                     |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : rioc_trip_properties

bind rioc_trip_top rioc_trip_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .function_block_in_i(function_block_in_i),
  .internal_trip_o(internal_trip_o), .general_trip_out_o(general_trip_out_o),
  .irq_o(irq_o)
);

`default_nettype wire

// [tb/rioc_trip_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module rioc_trip_top_tb;
  logic               clk_i;
  logic               rst_i;
  logic               cyc;
  logic               stb;
  logic               we;
  logic [7:0]         adr;
  logic [3:0]         sel;
  logic [31:0]        wdat;
  logic [31:0]        rdat;
  logic               ack;
  logic               s_vld;
  logic signed [15:0] s_dat;
  logic               r_vld;
  logic [15:0]        r_dat;
  logic               dbl;
  logic               blk;
  logic               itrip;
  logic               gtrip;
  logic               irq;
  int                 failures = 0;
  int                 checks = 0;
  int                 cycles = 0;
  logic [11:0]        pw [6] = '{12'h009, 12'h00a, 12'h3e9, 12'h3e8, 12'hbb9, 12'hbb8};
  logic [11:0]        pe [6] = '{12'h0c8, 12'h00a, 12'h00a, 12'h3e8, 12'h3e8, 12'hbb8};

  rioc_trip_top uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sample_valid_i(s_vld), .sample_i(s_dat), .rms_valid_i(r_vld),
    .fundamental_rms_i(r_dat), .setting_double_in_i(dbl), .function_block_in_i(blk),
    .internal_trip_o(itrip), .general_trip_out_o(gtrip), .irq_o(irq)
  );

  rioc_front_model fm (
    .clk_i(clk_i), .sample_valid_o(s_vld), .sample_o(s_dat), .rms_valid_o(r_vld),
    .rms_o(r_dat)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
  begin
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask : wrap_up

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask : check

  // No fixed answer time is assumed; only the cycle ceiling ends a wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
  begin
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    if (!w)
      check(rdat, exp);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, exp);
  endtask : rd

  // Expected value packs internal, general and irq
  task automatic outs(input logic [2:0] e);
  begin
    @(negedge clk_i);
    check({29'h0, itrip, gtrip, irq}, {29'h0, e});
    @(posedge clk_i);
  end
  endtask : outs

  task automatic fund(input logic [15:0] v, input logic [2:0] e);
  begin
    fm.send_rms(v);
    outs(e);
  end
  endtask : fund

  task automatic peak(input logic [15:0] v, input int n, input logic [2:0] e);
  begin
    fm.send_samples(v, n);
    @(posedge clk_i);
    outs(e);
  end
  endtask : peak

  // Binary inputs pass two synchroniser stages before they act
  task automatic settle(input logic [2:0] e);
  begin
    repeat (4) @(posedge clk_i);
    outs(e);
  end
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    dbl = 1'b0;
    blk = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(rioc_pkg::OFS_CTRL, 32'h0);
    rd(rioc_pkg::OFS_PICKUP, 32'h0c8);
    rd(8'h40, 32'h0);
    wr(rioc_pkg::OFS_RATED, 32'h64);
    fund(16'h7fff, 3'b000);
    $display("test defaults done");
    for (int i = 0; i < 6; i++)
    begin
      if (i == 4)
        wr(rioc_pkg::OFS_CTRL, 32'h10);
      wr(rioc_pkg::OFS_PICKUP, {20'h0, pw[i]});
      rd(rioc_pkg::OFS_PICKUP, {20'h0, pe[i]});
    end
    wr(rioc_pkg::OFS_PICKUP, 32'h0c8);
    // Upper three bytes only: the low byte must keep its stored value
    sel <= 4'he;
    wr(rioc_pkg::OFS_PICKUP, 32'h300);
    sel <= 4'hf;
    rd(rioc_pkg::OFS_PICKUP, 32'h3c8);
    wr(rioc_pkg::OFS_PICKUP, 32'h0c8);
    wr(rioc_pkg::OFS_CTRL, 32'h2);
    $display("test pickup range done");
    fund(16'h00c8, 3'b000);
    fund(16'h00c9, 3'b110);
    dbl <= 1'b1;
    settle(3'b000);
    rd(rioc_pkg::OFS_STATUS, 32'h8);
    fund(16'h0190, 3'b000);
    fund(16'h0191, 3'b110);
    dbl <= 1'b0;
    fund(16'h0000, 3'b000);
    wr(rioc_pkg::OFS_IRQ_STAT, 32'h7);
    fund(16'h012c, 3'b110);
    rd(rioc_pkg::OFS_IRQ_STAT, 32'h1);
    rd(rioc_pkg::OFS_MEAS, 32'h12c);
    wr(rioc_pkg::OFS_IRQ_MASK, 32'h1);
    settle(3'b111);
    wr(rioc_pkg::OFS_IRQ_STAT, 32'h1);
    settle(3'b110);
    wr(rioc_pkg::OFS_IRQ_MASK, 32'h0);
    blk <= 1'b1;
    settle(3'b100);
    rd(rioc_pkg::OFS_STATUS, 32'h5);
    rd(rioc_pkg::OFS_IRQ_STAT, 32'h6);
    blk <= 1'b0;
    settle(3'b110);
    rd(rioc_pkg::OFS_TRIP_CNT, 32'h4);
    wr(rioc_pkg::OFS_CTRL, 32'h3);
    settle(3'b000);
    $display("test fundamental done");
    wr(rioc_pkg::OFS_CTRL, 32'h1);
    fund(16'h1388, 3'b000);
    peak(16'h0032, 1, 3'b000);
    peak(16'hff38, 1, 3'b000);
    peak(16'hff37, 1, 3'b110);
    peak(16'h0000, 45, 3'b000);
    rd(rioc_pkg::OFS_TRIP_CNT, 32'h5);
    wr(rioc_pkg::OFS_TRIP_CNT, 32'h0);
    rd(rioc_pkg::OFS_TRIP_CNT, 32'h0);
    $display("test peak done");
    wrap_up();
  end
endmodule : rioc_trip_top_tb

`default_nettype wire
